// ### inc/dic_pkg.sv
package dic_pkg;

  // Input count and word widths.
  localparam int unsigned NUM_INPUTS = 16;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned SUB_W      = 8;
  localparam int unsigned SF_COUNT   = 3;

  // Settings word split: low half special functions, high half input levels.
  localparam int unsigned LEVEL_BASE = 16;

  // Special-function bit positions in the enable, polarity and force words and in the status word.
  localparam int unsigned SF_NEG_LIMIT_BIT = 0;
  localparam int unsigned SF_POS_LIMIT_BIT = 1;
  localparam int unsigned SF_HOME_BIT      = 2;

  // Inputs (zero based) that serve as clock and direction in step mode.
  localparam int unsigned CLK_INPUT_IDX = 4;
  localparam int unsigned DIR_INPUT_IDX = 5;

  // Input (zero based) watched for position capture: digital input 2.
  localparam int unsigned CAPTURE_INPUT_IDX = 1;

  // Subentry numbers of the control entry.
  localparam logic [SUB_W-1:0] SUB_HIGHEST   = 8'h00;
  localparam logic [SUB_W-1:0] SUB_SF_ENABLE = 8'h01;
  localparam logic [SUB_W-1:0] SUB_POLARITY  = 8'h02;
  localparam logic [SUB_W-1:0] SUB_FORCE_EN  = 8'h03;
  localparam logic [SUB_W-1:0] SUB_FORCE_VAL = 8'h04;
  localparam logic [SUB_W-1:0] SUB_RAW       = 8'h05;
  localparam logic [SUB_W-1:0] SUB_RANGE     = 8'h06;
  localparam logic [SUB_W-1:0] SUB_DIFF      = 8'h07;
  localparam logic [SUB_W-1:0] SUB_ROUTING   = 8'h08;

  // Reset values.
  localparam logic [SUB_W-1:0]  RST_HIGHEST   = 8'h08;
  localparam logic [WORD_W-1:0] RST_SF_ENABLE = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_POLARITY  = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_FORCE_EN  = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_FORCE_VAL = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_RAW       = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_RANGE     = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_DIFF      = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_ROUTING   = 32'h0000_0000;

  // Software access request to one subentry.
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [SUB_W-1:0]  sub;
    logic [WORD_W-1:0] wdata;
  } dic_req_t;

  // Answer to a request, one cycle after it is taken.
  typedef struct packed {
    logic              ack;
    logic              err;
    logic [WORD_W-1:0] rdata;
  } dic_rsp_t;

  // Special-function states after conditioning.
  typedef struct packed {
    logic home;
    logic pos_limit;
    logic neg_limit;
  } dic_sf_t;

endpackage : dic_pkg

// ### rtl/dic_input_cond.sv
// Overview of operation
// - Each special function is off while its enable bit is 0 and active while it is 1.
// - The special-function enable word has no effect at all on status bits 16 to 31.
// - Special-function bit 0 is the negative limit, bit 1 the positive limit, bit 2 home.
// - Polarity bit 0 reports a high level as 1, polarity bit 1 reports a high level as 0.
// - Inversion covers normal inputs and special functions but not clock and direction in step mode.
// - A set force-enable bit replaces the real level by the software value.
// - For a forced input the matching force-value bit is taken as its level ahead of the polarity inversion.
// - A readable word holds the input levels before any inversion or forcing.
// - Range bit n at 0 selects the 5 V threshold and at 1 the 24 V one for input n+1.
// - A combined status word summarizes conditioned levels and special functions.
// - A level change on digital input 2 captures the encoder position.
// - In the polarity and force words bits 0-15 govern special functions, bits 16-31 levels; the enable word uses bits 0-2 only.
`timescale 1ns/1ps

module dic_input_cond (
  input  wire logic                               sys_clk_in,
  input  wire logic                               rst_in,
  input  wire logic [dic_pkg::NUM_INPUTS-1:0]     pins_in,
  input  wire logic                               step_mode_in,
  input  wire logic [dic_pkg::WORD_W-1:0]         enc_pos_in,
  input  wire dic_pkg::dic_req_t                  req_in,
  output dic_pkg::dic_rsp_t                       rsp_out,
  output logic      [dic_pkg::WORD_W-1:0]         status_word_out,
  output dic_pkg::dic_sf_t                        sf_out,
  output logic      [dic_pkg::NUM_INPUTS-1:0]     thr_24v_out,
  output logic      [dic_pkg::NUM_INPUTS-1:0]     diff_sel_out,
  output logic      [dic_pkg::NUM_INPUTS-1:0]     route_en_out,
  output logic                                    capture_pulse_out,
  output logic      [dic_pkg::WORD_W-1:0]         capture_pos_out
);
  import dic_pkg::*;

  // Settings registers.
  logic [WORD_W-1:0] sf_enable_ff;
  logic [WORD_W-1:0] nxt_sf_enable;
  logic [WORD_W-1:0] polarity_ff;
  logic [WORD_W-1:0] nxt_polarity;
  logic [WORD_W-1:0] force_en_ff;
  logic [WORD_W-1:0] nxt_force_en;
  logic [WORD_W-1:0] force_val_ff;
  logic [WORD_W-1:0] nxt_force_val;
  logic [WORD_W-1:0] range_ff;
  logic [WORD_W-1:0] nxt_range;
  logic [WORD_W-1:0] diff_ff;
  logic [WORD_W-1:0] nxt_diff;
  logic [WORD_W-1:0] routing_ff;
  logic [WORD_W-1:0] nxt_routing;
  dic_rsp_t          rsp_ff;
  dic_rsp_t          nxt_rsp;

  // Input path registers.
  logic [WORD_W-1:0] raw_ff;
  logic [WORD_W-1:0] nxt_raw;
  logic [WORD_W-1:0] status_ff;
  logic [WORD_W-1:0] nxt_status;
  dic_sf_t           sf_ff;
  dic_sf_t           nxt_sf;
  logic              cap_prev_ff;
  logic              nxt_cap_prev;
  logic              cap_seen_ff;
  logic              nxt_cap_seen;
  logic              cap_pulse_ff;
  logic              nxt_cap_pulse;
  logic [WORD_W-1:0] cap_pos_ff;
  logic [WORD_W-1:0] nxt_cap_pos;

  // Conditioned values, combinational.
  logic [NUM_INPUTS-1:0] lvl_forced;
  logic [NUM_INPUTS-1:0] lvl_cond;
  logic [NUM_INPUTS-1:0] sf_forced;
  logic [NUM_INPUTS-1:0] sf_cond;
  logic [NUM_INPUTS-1:0] inv_guard;

  // Settings writes and read answers.
  always_comb begin
    nxt_sf_enable = sf_enable_ff;
    nxt_polarity  = polarity_ff;
    nxt_force_en  = force_en_ff;
    nxt_force_val = force_val_ff;
    nxt_range     = range_ff;
    nxt_diff      = diff_ff;
    nxt_routing   = routing_ff;
    nxt_rsp       = '0;
    if (req_in.wr) begin
      nxt_rsp.ack = 1'b1;
      if (req_in.sub == SUB_SF_ENABLE) begin
        nxt_sf_enable = req_in.wdata;
      end else if (req_in.sub == SUB_POLARITY) begin
        nxt_polarity = req_in.wdata;
      end else if (req_in.sub == SUB_FORCE_EN) begin
        nxt_force_en = req_in.wdata;
      end else if (req_in.sub == SUB_FORCE_VAL) begin
        nxt_force_val = req_in.wdata;
      end else if (req_in.sub == SUB_RAW) begin
        // The raw word mirrors the pins every cycle, so a write has no lasting effect.
        nxt_rsp.err = 1'b0;
      end else if (req_in.sub == SUB_RANGE) begin
        nxt_range = req_in.wdata;
      end else if (req_in.sub == SUB_DIFF) begin
        nxt_diff = req_in.wdata;
      end else if (req_in.sub == SUB_ROUTING) begin
        nxt_routing = req_in.wdata;
      end else begin
        // The highest-subentry count is read only; other numbers do not exist.
        nxt_rsp.err = 1'b1;
      end
    end else if (req_in.rd) begin
      nxt_rsp.ack = 1'b1;
      if (req_in.sub == SUB_HIGHEST) begin
        nxt_rsp.rdata = {{(WORD_W-SUB_W){1'b0}}, RST_HIGHEST};
      end else if (req_in.sub == SUB_SF_ENABLE) begin
        nxt_rsp.rdata = sf_enable_ff;
      end else if (req_in.sub == SUB_POLARITY) begin
        nxt_rsp.rdata = polarity_ff;
      end else if (req_in.sub == SUB_FORCE_EN) begin
        nxt_rsp.rdata = force_en_ff;
      end else if (req_in.sub == SUB_FORCE_VAL) begin
        nxt_rsp.rdata = force_val_ff;
      end else if (req_in.sub == SUB_RAW) begin
        nxt_rsp.rdata = raw_ff;
      end else if (req_in.sub == SUB_RANGE) begin
        nxt_rsp.rdata = range_ff;
      end else if (req_in.sub == SUB_DIFF) begin
        nxt_rsp.rdata = diff_ff;
      end else if (req_in.sub == SUB_ROUTING) begin
        nxt_rsp.rdata = routing_ff;
      end else begin
        nxt_rsp.err = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sf_enable_ff <= RST_SF_ENABLE;
      polarity_ff  <= RST_POLARITY;
      force_en_ff  <= RST_FORCE_EN;
      force_val_ff <= RST_FORCE_VAL;
      range_ff     <= RST_RANGE;
      diff_ff      <= RST_DIFF;
      routing_ff   <= RST_ROUTING;
      rsp_ff       <= '0;
    end else begin
      sf_enable_ff <= nxt_sf_enable;
      polarity_ff  <= nxt_polarity;
      force_en_ff  <= nxt_force_en;
      force_val_ff <= nxt_force_val;
      range_ff     <= nxt_range;
      diff_ff      <= nxt_diff;
      routing_ff   <= nxt_routing;
      rsp_ff       <= nxt_rsp;
    end
  end

  // Conditioning of levels and special functions.
  always_comb begin
    inv_guard = '1;
    if (step_mode_in) begin
      inv_guard[CLK_INPUT_IDX] = 1'b0;
      inv_guard[DIR_INPUT_IDX] = 1'b0;
    end
    lvl_forced = (pins_in & ~force_en_ff[WORD_W-1:LEVEL_BASE])
               | (force_val_ff[WORD_W-1:LEVEL_BASE] & force_en_ff[WORD_W-1:LEVEL_BASE]);
    lvl_cond   = lvl_forced ^ (polarity_ff[WORD_W-1:LEVEL_BASE] & inv_guard);
    sf_forced  = (pins_in & ~force_en_ff[LEVEL_BASE-1:0])
               | (force_val_ff[LEVEL_BASE-1:0] & force_en_ff[LEVEL_BASE-1:0]);
    sf_cond    = sf_forced ^ (polarity_ff[LEVEL_BASE-1:0] & inv_guard);
  end

  always_comb begin
    nxt_raw = {pins_in, pins_in};
    nxt_sf  = '0;
    nxt_sf.neg_limit = sf_cond[SF_NEG_LIMIT_BIT] & sf_enable_ff[SF_NEG_LIMIT_BIT];
    nxt_sf.pos_limit = sf_cond[SF_POS_LIMIT_BIT] & sf_enable_ff[SF_POS_LIMIT_BIT];
    nxt_sf.home      = sf_cond[SF_HOME_BIT] & sf_enable_ff[SF_HOME_BIT];
    nxt_status = '0;
    nxt_status[WORD_W-1:LEVEL_BASE] = lvl_cond;
    nxt_status[SF_NEG_LIMIT_BIT]    = nxt_sf.neg_limit;
    nxt_status[SF_POS_LIMIT_BIT]    = nxt_sf.pos_limit;
    nxt_status[SF_HOME_BIT]         = nxt_sf.home;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_ff    <= RST_RAW;
      sf_ff     <= '0;
      status_ff <= '0;
    end else begin
      raw_ff    <= nxt_raw;
      sf_ff     <= nxt_sf;
      status_ff <= nxt_status;
    end
  end

  // Position capture on digital input 2; the first sample after reset only arms it.
  always_comb begin
    nxt_cap_prev  = pins_in[CAPTURE_INPUT_IDX];
    nxt_cap_seen  = 1'b1;
    nxt_cap_pulse = 1'b0;
    nxt_cap_pos   = cap_pos_ff;
    if (cap_seen_ff && (pins_in[CAPTURE_INPUT_IDX] != cap_prev_ff)) begin
      nxt_cap_pulse = 1'b1;
      nxt_cap_pos   = enc_pos_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_prev_ff  <= 1'b0;
      cap_seen_ff  <= 1'b0;
      cap_pulse_ff <= 1'b0;
      cap_pos_ff   <= '0;
    end else begin
      cap_prev_ff  <= nxt_cap_prev;
      cap_seen_ff  <= nxt_cap_seen;
      cap_pulse_ff <= nxt_cap_pulse;
      cap_pos_ff   <= nxt_cap_pos;
    end
  end

  assign rsp_out           = rsp_ff;
  assign status_word_out   = status_ff;
  assign sf_out            = sf_ff;
  assign thr_24v_out       = range_ff[NUM_INPUTS-1:0];
  assign diff_sel_out      = diff_ff[NUM_INPUTS-1:0];
  assign route_en_out      = routing_ff[NUM_INPUTS-1:0];
  assign capture_pulse_out = cap_pulse_ff;
  assign capture_pos_out   = cap_pos_ff;

endmodule : dic_input_cond

// ### verification/dic_input_cond_props.sv
`timescale 1ns/1ps
module dic_input_cond_props (
  input wire logic                           sys_clk_in,
  input wire logic                           rst_in,
  input wire logic [dic_pkg::NUM_INPUTS-1:0] pins_in,
  input wire logic [dic_pkg::WORD_W-1:0]     enc_pos_in,
  input wire dic_pkg::dic_req_t              req_in,
  input wire dic_pkg::dic_rsp_t              rsp_out,
  input wire logic [dic_pkg::WORD_W-1:0]     status_word_out,
  input wire dic_pkg::dic_sf_t               sf_out,
  input wire logic                           capture_pulse_out,
  input wire logic [dic_pkg::WORD_W-1:0]     capture_pos_out
);
  import dic_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ack_follows_req: assert property ((req_in.rd || req_in.wr) |=> rsp_out.ack)
    else $error("no ack after request");
  a_no_stray_ack: assert property (!(req_in.rd || req_in.wr) |=> !rsp_out.ack)
    else $error("ack without request");
  a_bad_write_err: assert property (req_in.wr && (req_in.sub == 8'h00 || req_in.sub > 8'h08)
    |=> rsp_out.err && rsp_out.rdata == 32'h0) else $error("bad write not refused");
  a_highest_read: assert property (req_in.rd && !req_in.wr && req_in.sub == SUB_HIGHEST
    |=> !rsp_out.err && rsp_out.rdata == {24'h0, RST_HIGHEST}) else $error("bad count read");
  a_status_gap: assert property (status_word_out[15:3] == 13'h0)
    else $error("unused status bits set");
  a_sf_mirror: assert property (sf_out == status_word_out[2:0])
    else $error("special outputs differ from status");
  a_capture_edge: assert property (capture_pulse_out |-> $past(pins_in[1]) != $past(pins_in[1], 2))
    else $error("capture without change");
  a_capture_fires: assert property (!$past(rst_in, 3) && $past(pins_in[1]) != $past(pins_in[1], 2)
    |-> capture_pulse_out && capture_pos_out == $past(enc_pos_in)) else $error("capture missed");
endmodule : dic_input_cond_props

bind dic_input_cond dic_input_cond_props dic_input_cond_props_inst (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .pins_in(pins_in), .enc_pos_in(enc_pos_in),
  .req_in(req_in), .rsp_out(rsp_out), .status_word_out(status_word_out), .sf_out(sf_out),
  .capture_pulse_out(capture_pulse_out), .capture_pos_out(capture_pos_out));

// ### verification/dic_switch_model.sv
`timescale 1ns/1ps
module dic_switch_model (
  input  wire logic [dic_pkg::NUM_INPUTS-1:0] want_in,
  input  wire logic                           sys_clk_in,
  output logic      [dic_pkg::NUM_INPUTS-1:0] pins_out
);
  // Switch levels settle away from the sampling edge, so the block never sees a race.
  always @(negedge sys_clk_in) begin
    pins_out <= want_in;
  end
endmodule : dic_switch_model

// ### verification/tb_dic_input_cond.sv
`timescale 1ns/1ps
module tb_dic_input_cond;
  import dic_pkg::*;
  logic                  sys_clk_in = 1'b0;
  logic                  rst_in     = 1'b1;
  logic                  step_mode  = 1'b0;
  logic [WORD_W-1:0]     enc_pos    = 32'h0;
  logic [NUM_INPUTS-1:0] want       = 16'h0;
  logic [NUM_INPUTS-1:0] pins, thr, diff, route;
  logic [WORD_W-1:0]     status, cap_pos;
  logic [WORD_W-1:0]     cfg [9];
  dic_req_t              req = '0;
  dic_rsp_t              rsp;
  dic_sf_t               sf;
  logic                  cap;
  int error_cnt = 0;
  int n_tests   = 0;
  int cyc       = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  dic_switch_model dic_switch_model_inst (.want_in(want), .sys_clk_in(sys_clk_in), .pins_out(pins));
  dic_input_cond dic_input_cond_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pins_in(pins),
    .step_mode_in(step_mode), .enc_pos_in(enc_pos), .req_in(req), .rsp_out(rsp),
    .status_word_out(status), .sf_out(sf), .thr_24v_out(thr), .diff_sel_out(diff),
    .route_en_out(route), .capture_pulse_out(cap), .capture_pos_out(cap_pos));
  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [WORD_W+1:0] e, input logic [WORD_W+1:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // The answer is sampled before the request drops, in the cycle it stands.
  task automatic acc(input logic r, input logic w, input logic [SUB_W-1:0] s,
                     input logic [WORD_W-1:0] d, input logic [WORD_W:0] e);
    @(negedge sys_clk_in);
    req = '{rd: r, wr: w, sub: s, wdata: d};
    @(negedge sys_clk_in);
    chk("rsp", {1'b1, e}, rsp);
    req = '0;
  endtask : acc
  task automatic wrs(input int s, input logic [WORD_W-1:0] d);
    acc(1'b0, 1'b1, s[7:0], d, 33'h0);
    cfg[s] = d;
  endtask : wrs
  function automatic logic [WORD_W-1:0] exp_status();
    logic [15:0] inv;
    logic [15:0] lv;
    logic [2:0]  s;
    inv = cfg[2][31:16];
    if (step_mode) inv[5:4] = 2'b00;
    lv = (cfg[3][31:16] & cfg[4][31:16]) | (~cfg[3][31:16] & pins);
    s = (((cfg[3][2:0] & cfg[4][2:0]) | (~cfg[3][2:0] & pins[2:0])) ^ cfg[2][2:0]) & cfg[1][2:0];
    return {lv ^ inv, 13'h0, s};
  endfunction : exp_status
  task automatic chk_status();
    logic [WORD_W-1:0] e;
    repeat (2) @(negedge sys_clk_in);
    e = exp_status();
    chk("status", {2'b00, e}, {2'b00, status});
    chk("sf", {31'h0, e[2:0]}, {31'h0, sf});
  endtask : chk_status
  task automatic t_regs();
    for (int i = 0; i <= 9; i++) begin
      acc(1'b1, 1'b0, i[7:0], 32'h0, (i == 0) ? 33'h8 : ((i == 9) ? 33'h1_0000_0000 : 33'h0));
    end
    acc(1'b0, 1'b1, SUB_HIGHEST, 32'h1234_5678, 33'h1_0000_0000);
  endtask : t_regs
  task automatic t_sf();
    want = 16'h0035;
    chk_status();
    wrs(1, 32'hffff_0007);
    chk_status();
    wrs(2, 32'h0033_0002);
    chk_status();
    step_mode = 1'b1;
    chk_status();
    step_mode = 1'b0;
  endtask : t_sf
  task automatic t_force();
    wrs(3, 32'h0003_0003);
    wrs(4, 32'h0002_0002);
    chk_status();
    acc(1'b1, 1'b0, SUB_RAW, 32'h0, {1'b0, pins, pins});
    acc(1'b0, 1'b1, SUB_RAW, 32'hffff_ffff, 33'h0);
    acc(1'b1, 1'b0, SUB_RAW, 32'h0, {1'b0, pins, pins});
  endtask : t_force
  task automatic t_range();
    for (int i = 6; i <= 8; i++) begin
      wrs(i, 32'h5a5a_a5a5 ^ i);
      acc(1'b1, 1'b0, i[7:0], 32'h0, {1'b0, cfg[i]});
    end
    @(negedge sys_clk_in);
    chk("thr", {18'h0, cfg[6][15:0]}, {18'h0, thr});
    chk("diff", {18'h0, cfg[7][15:0]}, {18'h0, diff});
    chk("route", {18'h0, cfg[8][15:0]}, {18'h0, route});
  endtask : t_range
  task automatic t_capture();
    logic seen;
    for (int k = 0; k < 2; k++) begin
      seen = 1'b0;
      enc_pos = 32'h1234_0000 + k;
      want[1] = ~want[1];
      for (int j = 0; j < 6 && !seen; j++) begin
        @(negedge sys_clk_in);
        seen = (cap === 1'b1);
      end
      chk("cap", 34'h1, {33'h0, seen});
      chk("cap_pos", {2'b00, enc_pos}, {2'b00, cap_pos});
      @(negedge sys_clk_in);
      chk("cap_end", 34'h0, {33'h0, cap});
    end
  endtask : t_capture
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    cfg = '{default: 32'h0};
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_regs();
    t_sf();
    t_force();
    t_range();
    t_capture();
    test_done();
  end
endmodule : tb_dic_input_cond
